// *** logic/dcp_dma_prog.sv ***
// dma channel programming block with transfer descriptor fifo
// Functional notes
// R1 - master disable stops all dma cycles
// R2 - address hold freezes channel 0 address; the code applies it only in memory-to-memory mode
// R3 - memory-to-memory bit pairs channels 0 and 1
// R4 - mode write: low bits pick channel
// R5 - mode reads step through channels, low ones
// R6 - top mode bits pick operating mode
// R7 - direction bit makes address count down
// R8 - auto reload restores current from base
// R9 - transfer type verify/write/read, 11 illegal
// R10 - request write sets or clears one bit
// R11 - software requests ignore the mask
// R12 - request read: bits 0-3, upper ones
// R13 - single mask write sets/clears one mask
// R14 - all-mask write and read, four bits
// R15 - masks set at reset, tc; clear cmd; the code sets a mask at tc only when auto reload is off
// R16 - status: tc flags low, pending high
// R17 - special commands use strobe, ignore data
// R18 - pointer commands select low or high byte
// R19 - master clear acts like hardware reset; the code leaves mode, address and count registers to hardware reset only
// R20 - mode counter clear restarts at channel 0
// R21 - host disables before reprogramming channels
// R22 - count rolls past zero signals terminal count
// R23 - terminal count reload copies base values
// R24 - byte pointer toggles per address/count access
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// small synchronous fifo
// ----------------------------------------------------------------
module dcp_fifo import dcp_pkg::*; #(
   parameter int WIDTH = DCP_FIFO_WIDTH,
   parameter int DEPTH = DCP_FIFO_DEPTH
) (
   input  wire logic             clock_i,   // system clock
   input  wire logic             rst_n_i,   // sync reset, low
   input  wire logic             clr_i,     // flush
   input  wire logic             in_valid_i, // write request
   output logic                  in_ready_o, // not full
   input  wire logic [WIDTH-1:0] in_data_i, // write data
   output logic                  out_valid_o, // not empty
   input  wire logic             out_ready_i, // read accept
   output logic      [WIDTH-1:0] out_data_o // head entry
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      fill_reg;
   logic             push;
   logic             pop;

   assign in_ready_o  = (fill_reg < (AW+1)'(DEPTH));
   assign out_valid_o = (fill_reg != '0);
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;
   assign out_data_o  = mem_reg[rd_ptr_reg];

   always_ff @(posedge clock_i) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i || clr_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         fill_reg   <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
         end
         if (pop) begin
            rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
         end
         fill_reg <= fill_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// ----------------------------------------------------------------
// channel programming and transfer sequencing
// ----------------------------------------------------------------
module dcp_dma_prog import dcp_pkg::*; (
   input  wire logic        clock_i,             // 100 MHz clock
   input  wire logic        rst_n_i,             // sync reset, low
   input  wire logic [4:0]  io_addr_i,           // register index
   input  wire logic [7:0]  io_data_i,           // write data
   input  wire logic        io_read_strobe_n_i,  // i/o read, low
   input  wire logic        io_write_strobe_n_i, // i/o write, low
   output logic      [7:0]  io_data_o,           // read data
   output logic             io_data_oe_o,        // high while driving data
   input  wire logic [3:0]  dreq_i,              // external requests
   output logic             xfer_valid_o,        // descriptor available
   input  wire logic        xfer_ready_i,        // descriptor taken
   output logic      [1:0]  xfer_chan_o,         // channel of transfer
   output logic      [1:0]  xfer_type_o,         // verify/write/read
   output logic      [15:0] xfer_addr_o,         // transfer address
   output logic             xfer_tc_o            // last transfer of block
);
   // ----------------------------------------------------------------
   // strobe edge detection and decode
   // ----------------------------------------------------------------
   logic rd_q_reg, wr_q_reg, rd_fall, wr_fall, mclr, clr;

   // idle level at reset, so a strobe already low when reset ends is seen as an edge
   always_ff @(posedge clock_i) begin
      rd_q_reg <= !rst_n_i || io_read_strobe_n_i;
      wr_q_reg <= !rst_n_i || io_write_strobe_n_i;
   end

   assign rd_fall = rd_q_reg && !io_read_strobe_n_i;
   assign wr_fall = wr_q_reg && !io_write_strobe_n_i;

   // strobe alone triggers commands; data and direction ignored
   function automatic logic hit(input logic [4:0] idx);
      hit = (rd_fall || wr_fall) && (io_addr_i == idx); // R17
   endfunction

   logic wr_cmd, wr_req, wr_sgl, wr_mode, wr_all, rd_stat, rd_mode, ab_acc;
   assign mclr    = hit(DCP_IDX_MCLR);
   assign clr     = !rst_n_i || mclr;             // R19
   assign wr_cmd  = wr_fall && io_addr_i == DCP_IDX_CMD_STAT;
   assign wr_req  = wr_fall && io_addr_i == DCP_IDX_SW_REQ;
   assign wr_sgl  = wr_fall && io_addr_i == DCP_IDX_SGL_MASK;
   assign wr_mode = wr_fall && io_addr_i == DCP_IDX_MODE;
   assign wr_all  = wr_fall && io_addr_i == DCP_IDX_ALL_MASK;
   assign rd_stat = rd_fall && io_addr_i == DCP_IDX_CMD_STAT;
   assign rd_mode = rd_fall && io_addr_i == DCP_IDX_MODE;
   assign ab_acc  = (rd_fall || wr_fall) && io_addr_i <= DCP_IDX_ADDR_LAST;

   // ----------------------------------------------------------------
   // command register, byte pointer, mode read counter
   // ----------------------------------------------------------------
   logic [7:0] cmd_reg;
   logic [1:0] mcnt_reg;
   logic       ptr_reg, master_disable, address_hold, mem_to_mem;

   always_ff @(posedge clock_i) begin
      if (clr) begin
         cmd_reg <= DCP_CMD_RESET;
      end else if (wr_cmd) begin
         cmd_reg <= io_data_i;
      end
   end
   assign master_disable = cmd_reg[DCP_CMD_DIS_BIT];
   assign address_hold   = cmd_reg[DCP_CMD_HOLD_BIT];
   assign mem_to_mem     = cmd_reg[DCP_CMD_MM_BIT];

   always_ff @(posedge clock_i) begin
      if (clr || hit(DCP_IDX_CLR_PTR)) begin
         ptr_reg <= 1'b0;                          // R18
      end else if (hit(DCP_IDX_SET_PTR)) begin
         ptr_reg <= 1'b1;                          // R18
      end else if (ab_acc) begin
         ptr_reg <= !ptr_reg;                      // R24
      end
   end

   always_ff @(posedge clock_i) begin
      if (clr || hit(DCP_IDX_CLR_MCNT)) begin
         mcnt_reg <= 2'b00;                        // R20
      end else if (rd_mode) begin
         mcnt_reg <= mcnt_reg + 1'b1;              // R5
      end
   end

   // ----------------------------------------------------------------
   // transfer sequencing
   // ----------------------------------------------------------------
   logic [5:0]  mode_reg  [4];
   logic [15:0] cur_addr  [4];
   logic [15:0] cur_cnt   [4];
   logic [3:0]  mask_reg, swreq_reg, tcflag_reg, pend_reg, want;
   logic [1:0]  step_ch, step_tt;
   logic        mm_phase_reg, fifo_in_ready, step, tc_hit;

   // the mask never gates software requests
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         want[i] = (swreq_reg[i] || (dreq_i[i] && !mask_reg[i])) // R11 R13
                   && (dcp_op_t'(mode_reg[i][DCP_MODE_OP_LSB-2 +: 2]) != DCP_OP_CASCADE); // R6
      end
   end

   always_comb begin
      step_ch = 2'd0;
      if (mem_to_mem) begin
         step_ch = {1'b0, mm_phase_reg};           // R3
      end else if (!want[0]) begin
         step_ch = want[1] ? 2'd1 : (want[2] ? 2'd2 : 2'd3);
      end
   end

   // fifo back-pressure stalls the sequencer
   assign step    = !master_disable && fifo_in_ready            // R1
                    && (mem_to_mem ? want[0] : (want != 4'b0000));
   assign tc_hit  = step && (cur_cnt[step_ch] == DCP_CNT_ZERO);  // R22
   assign step_tt = mem_to_mem ? (mm_phase_reg ? DCP_TT_WRITE : DCP_TT_READ)
                               : mode_reg[step_ch][DCP_MODE_TT_LSB-2 +: 2]; // R9

   always_ff @(posedge clock_i) begin
      if (clr || !mem_to_mem) begin
         mm_phase_reg <= 1'b0;
      end else if (step) begin
         mm_phase_reg <= !mm_phase_reg;            // R3
      end
   end

   // ----------------------------------------------------------------
   // per-channel state
   // ----------------------------------------------------------------
   generate
      for (genvar c = 0; c < 4; c++) begin : g_ch
         logic [15:0] base_addr_reg, base_cnt_reg, cur_addr_reg, cur_cnt_reg;
         logic        mine, done, auto, hold, ab_wr;

         assign mine  = step && step_ch == 2'(c);
         // a memory-to-memory block ends for both channels on channel 1's count
         assign done  = (mine && tc_hit)
                        || (c == 0 && mem_to_mem && step && step_ch == 2'd1 && tc_hit);
         assign auto  = mode_reg[c][DCP_MODE_AUTO-2];
         assign hold  = (c == 0) && mem_to_mem && address_hold;   // R2
         assign ab_wr = wr_fall && io_addr_i <= DCP_IDX_ADDR_LAST
                        && io_addr_i[2:1] == 2'(c);
         assign cur_addr[c] = cur_addr_reg;
         assign cur_cnt[c]  = cur_cnt_reg;

         always_ff @(posedge clock_i) begin
            if (!rst_n_i) begin
               mode_reg[c] <= DCP_MODE_RESET;
            end else if (wr_mode && io_data_i[1:0] == 2'(c)) begin
               mode_reg[c] <= io_data_i[7:2];      // R4
            end
         end

         // host writes load base and current together, one byte at a time
         always_ff @(posedge clock_i) begin
            if (!rst_n_i) begin
               base_addr_reg <= DCP_CNT_ZERO;
               base_cnt_reg  <= DCP_CNT_ZERO;
               cur_addr_reg  <= DCP_CNT_ZERO;
               cur_cnt_reg   <= DCP_CNT_ZERO;
            end else if (ab_wr && !io_addr_i[0]) begin
               base_addr_reg[{ptr_reg, 3'b000} +: 8] <= io_data_i;  // R24
               cur_addr_reg[{ptr_reg, 3'b000} +: 8]  <= io_data_i;
            end else if (ab_wr) begin
               base_cnt_reg[{ptr_reg, 3'b000} +: 8] <= io_data_i;   // R24
               cur_cnt_reg[{ptr_reg, 3'b000} +: 8]  <= io_data_i;
            end else if (done && auto) begin
               cur_addr_reg <= base_addr_reg;      // R8 R23
               cur_cnt_reg  <= base_cnt_reg;       // R23
            end else if (mine) begin
               cur_cnt_reg <= cur_cnt_reg - DCP_ADDR_STEP;            // R22
               if (!hold) begin
                  cur_addr_reg <= mode_reg[c][DCP_MODE_DOWN-2]
                                  ? cur_addr_reg - DCP_ADDR_STEP      // R7
                                  : cur_addr_reg + DCP_ADDR_STEP;     // R7
               end
            end
         end

         always_ff @(posedge clock_i) begin
            if (clr) begin
               mask_reg[c] <= DCP_MASK_RESET[c];   // R15
            end else if (hit(DCP_IDX_CLR_MASK)) begin
               mask_reg[c] <= 1'b0;                // R15
            end else if (wr_sgl && io_data_i[1:0] == 2'(c)) begin
               mask_reg[c] <= io_data_i[DCP_VALUE_BIT];   // R13
            end else if (wr_all) begin
               mask_reg[c] <= io_data_i[c];        // R14
            end else if (done && !auto) begin
               mask_reg[c] <= 1'b1;                // R15
            end
         end

         always_ff @(posedge clock_i) begin
            if (clr) begin
               swreq_reg[c] <= 1'b0;               // R12
            end else if (wr_req && io_data_i[1:0] == 2'(c)) begin
               swreq_reg[c] <= io_data_i[DCP_VALUE_BIT];  // R10
            end else if (done || (mine && dcp_op_t'(mode_reg[c][5:4]) == DCP_OP_SINGLE)) begin
               swreq_reg[c] <= 1'b0;
            end
         end

         // terminal count set wins over the clearing status read
         always_ff @(posedge clock_i) begin
            if (clr) begin
               tcflag_reg[c] <= 1'b0;
            end else if (done) begin
               tcflag_reg[c] <= 1'b1;              // R16
            end else if (rd_stat) begin
               tcflag_reg[c] <= 1'b0;              // R16
            end
         end

         always_ff @(posedge clock_i) begin
            pend_reg[c] <= !clr && dreq_i[c];      // R16
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // read data path
   // ----------------------------------------------------------------
   logic [7:0] rd_next;
   logic [15:0] ab_word;

   always_comb begin
      ab_word = io_addr_i[0] ? cur_cnt[io_addr_i[2:1]] : cur_addr[io_addr_i[2:1]];
      rd_next = DCP_RD_ZERO;
      if (io_addr_i <= DCP_IDX_ADDR_LAST) begin
         rd_next = ptr_reg ? ab_word[15:8] : ab_word[7:0];
      end else begin
         unique case (io_addr_i)
            DCP_IDX_CMD_STAT: rd_next = {pend_reg, tcflag_reg};        // R16
            DCP_IDX_SW_REQ:   rd_next = {DCP_REQ_RD_HIGH, swreq_reg};  // R12
            DCP_IDX_MODE:     rd_next = {mode_reg[mcnt_reg], DCP_MODE_RD_LOW}; // R5
            DCP_IDX_ALL_MASK: rd_next = {4'h0, mask_reg};              // R14
            DCP_IDX_CMD_RD:   rd_next = cmd_reg;
            default:          rd_next = DCP_RD_ZERO;
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         io_data_o <= DCP_RD_ZERO;
      end else if (rd_fall) begin
         io_data_o <= rd_next;
      end
   end

   assign io_data_oe_o = !io_read_strobe_n_i && !rd_fall;

   // ----------------------------------------------------------------
   // descriptor fifo
   // ----------------------------------------------------------------
   logic [DCP_FIFO_WIDTH-1:0] fifo_out;

   dcp_fifo #(.WIDTH(DCP_FIFO_WIDTH), .DEPTH(DCP_FIFO_DEPTH)) u_fifo (
      .clock_i     (clock_i),
      .rst_n_i     (rst_n_i),
      .clr_i       (mclr),
      .in_valid_i  (step),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   ({step_ch, step_tt, cur_addr[step_ch], tc_hit}),
      .out_valid_o (xfer_valid_o),
      .out_ready_i (xfer_ready_i),
      .out_data_o  (fifo_out)
   );
   assign {xfer_chan_o, xfer_type_o, xfer_addr_o, xfer_tc_o} = fifo_out;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_status_read;
      rd_stat && !(|g_ch[0].done);
   endsequence
   sequence s_flags_gone;
      ##1 tcflag_reg[0] == 1'b0;
   endsequence

   AST_DISABLE_NO_STEP: assert property (master_disable |-> !step) // R1
      else $error("step while disabled");
   AST_HOLD_ADDR: assert property (mem_to_mem && address_hold && step && !wr_fall // R2
      && !g_ch[0].done |=> $stable(cur_addr[0]))
      else $error("channel 0 address moved under hold");
   AST_MODE_WRITE: assert property (wr_mode && io_data_i[1:0] == 2'd2 && !clr // R4
      |=> mode_reg[2] == $past(io_data_i[7:2])) else $error("mode write lost");
   AST_MODE_READ_LOW: assert property (rd_mode |=> io_data_o[1:0] == 2'b11) // R5
      else $error("mode read low bits not ones");
   AST_REQ_READ: assert property (rd_fall && io_addr_i == DCP_IDX_SW_REQ // R12
      |=> io_data_o[7:4] == 4'hF && io_data_o[3:0] == $past(swreq_reg))
      else $error("request read wrong");
   AST_MASK_ON_TC: assert property (g_ch[1].done && !g_ch[1].auto && !clr // R15
      && !hit(DCP_IDX_CLR_MASK) && !wr_sgl && !wr_all |=> mask_reg[1])
      else $error("mask not set at terminal count");
   AST_STATUS_CLEAR: assert property (s_status_read and !mclr |-> s_flags_gone) // R16
      else $error("tc flag survives status read");
   AST_TC_SET: assert property (g_ch[2].done && !clr |=> tcflag_reg[2]) // R16
      else $error("tc flag not set");
   AST_RELOAD: assert property (g_ch[3].done && g_ch[3].auto && !g_ch[3].ab_wr // R23
      |=> cur_cnt[3] == $past(g_ch[3].base_cnt_reg)) else $error("count not reloaded");
   AST_PTR_TOGGLE: assert property (ab_acc && !clr // R24
      |=> ptr_reg != $past(ptr_reg)) else $error("byte pointer did not toggle");
   AST_MCLR_STATE: assert property (mclr |=> cmd_reg == 8'h00 && mask_reg == 4'hF // R19
      && swreq_reg == 4'h0 && mcnt_reg == 2'd0 && !ptr_reg)
      else $error("master clear incomplete");
endmodule

`default_nettype wire

// *** logic/dcp_pkg.sv ***
// constants shared by the dma channel programming block
package dcp_pkg;
   // ----------------------------------------------------------------
   // register port indices (5-bit i/o index)
   // ----------------------------------------------------------------
   localparam logic [4:0] DCP_IDX_ADDR_LAST  = 5'h0_7;  // 0..7 address/count bytes
   localparam logic [4:0] DCP_IDX_CMD_STAT   = 5'h0_8;  // write command, read status
   localparam logic [4:0] DCP_IDX_SW_REQ     = 5'h0_9;  // software_request
   localparam logic [4:0] DCP_IDX_SGL_MASK   = 5'h0_A;  // single_mask_write
   localparam logic [4:0] DCP_IDX_MODE       = 5'h0_B;  // channel_mode
   localparam logic [4:0] DCP_IDX_CLR_PTR    = 5'h0_C;  // strobe: pointer to low byte
   localparam logic [4:0] DCP_IDX_MCLR       = 5'h0_D;  // strobe: master clear
   localparam logic [4:0] DCP_IDX_CLR_MASK   = 5'h0_E;  // strobe: clear all masks
   localparam logic [4:0] DCP_IDX_ALL_MASK   = 5'h0_F;  // all_mask_bits
   localparam logic [4:0] DCP_IDX_SET_PTR    = 5'h1_0;  // strobe: pointer to high byte
   localparam logic [4:0] DCP_IDX_CLR_MCNT   = 5'h1_1;  // strobe: clear mode read counter
   localparam logic [4:0] DCP_IDX_CMD_RD     = 5'h1_2;  // command read-back
   // ----------------------------------------------------------------
   // command register fields
   // ----------------------------------------------------------------
   localparam int DCP_CMD_MM_BIT   = 0;
   localparam int DCP_CMD_HOLD_BIT = 1;
   localparam int DCP_CMD_DIS_BIT  = 2;
   // ----------------------------------------------------------------
   // mode register fields
   // ----------------------------------------------------------------
   localparam int DCP_MODE_OP_LSB  = 6;
   localparam int DCP_MODE_DOWN    = 5;
   localparam int DCP_MODE_AUTO    = 4;
   localparam int DCP_MODE_TT_LSB  = 2;
   localparam int DCP_SEL_LSB      = 0;
   localparam int DCP_VALUE_BIT    = 2;
   localparam logic [1:0] DCP_MODE_RD_LOW  = 2'h3;   // low mode bits read as ones
   localparam logic [3:0] DCP_REQ_RD_HIGH  = 4'hF;   // request read upper nibble
   localparam logic [5:0] DCP_MODE_RESET   = 6'h0_0;
   localparam logic [7:0] DCP_CMD_RESET    = 8'h0_0;
   localparam logic [3:0] DCP_MASK_RESET   = 4'hF;
   localparam logic [7:0] DCP_RD_ZERO      = 8'h0_0;
   localparam logic [15:0] DCP_CNT_ZERO    = 16'h0_000;
   localparam logic [15:0] DCP_ADDR_STEP   = 16'h0_001;
   // ----------------------------------------------------------------
   // encodings
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      DCP_OP_DEMAND,
      DCP_OP_SINGLE,
      DCP_OP_BLOCK,
      DCP_OP_CASCADE
   } dcp_op_t;
   typedef enum logic [1:0] {
      DCP_TT_VERIFY,
      DCP_TT_WRITE,
      DCP_TT_READ,
      DCP_TT_ILLEGAL
   } dcp_tt_t;
   localparam int DCP_FIFO_DEPTH = 8;
   localparam int DCP_FIFO_WIDTH = 21;             // chan, type, addr, tc
endpackage

// *** bench/dcp_xfer_sink.sv ***
// transfer descriptor consumer model, stalls on request or at random
`timescale 1ns/100ps
`default_nettype none
module dcp_xfer_sink (
   input  wire logic clock_i, // system clock
   input  wire logic rst_n_i, // sync reset, low
   input  wire logic stall_i, // hold off all takes
   output logic      ready_o  // take head entry
);
   // random gaps so both prompt and slow takes occur
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) ready_o <= 1'b0;
      else ready_o <= !stall_i && ($urandom_range(0, 3) != 0);
   end
endmodule
`default_nettype wire

// *** bench/dma_channel_programming_tb_top.sv ***
// self-checking bench for the dma channel programming block
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module dma_channel_programming_tb_top import dcp_pkg::*;;
   logic       clock_i, rst_n_i, rs_n, ws_n, ready, stall, oe, oe_q, valid, tc;
   logic [4:0] idx;
   logic [3:0] dreq;
   logic [7:0] din, dout, e8, m [4];
   logic [1:0] ch, tt;
   logic [15:0] addr, a3;
   logic [20:0] e21;
   int         failures, n_checks, cyc;
   logic [7:0] rq [$];
   logic [20:0] xq [$];
   dcp_dma_prog u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .io_addr_i(idx), .io_data_i(din),
      .io_read_strobe_n_i(rs_n), .io_write_strobe_n_i(ws_n), .io_data_o(dout),
      .io_data_oe_o(oe), .dreq_i(dreq), .xfer_valid_o(valid), .xfer_ready_i(ready),
      .xfer_chan_o(ch), .xfer_type_o(tt), .xfer_addr_o(addr), .xfer_tc_o(tc));
   dcp_xfer_sink u_sink (.clock_i(clock_i), .rst_n_i(rst_n_i), .stall_i(stall), .ready_o(ready));
   task automatic test_done();
      if (failures == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // strobe held low three edges, then seen high before the next access
   task automatic io(input logic wr, input logic [4:0] i, input logic [7:0] d);
      @(posedge clock_i);
      idx <= i;
      din <= d;
      if (wr) ws_n <= 1'b0;
      else rs_n <= 1'b0;
      repeat (3) @(posedge clock_i);
      ws_n <= 1'b1;
      rs_n <= 1'b1;
      @(posedge clock_i);
   endtask
   task automatic wr(input logic [4:0] i, input logic [7:0] d);
      io(1'b1, i, d);
   endtask
   task automatic rd(input logic [4:0] i, input logic [7:0] e);
      rq.push_back(e);
      io(1'b0, i, 8'($urandom));
   endtask
   initial begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   // watcher: read data on oe rise, descriptors on handshake
   always @(posedge clock_i) begin
      cyc++;
      if (oe && !oe_q) begin
         if (rq.size() == 0) failures++;
         else begin e8 = rq.pop_front(); `CHK(dout, e8) end
      end
      oe_q = oe;
      if (valid && ready) begin
         if (xq.size() == 0) failures++;
         else begin e21 = xq.pop_front(); `CHK({ch, tt, addr, tc}, e21) end
      end
      if (cyc == 20000) begin failures++; test_done(); end
   end
   initial begin
      rst_n_i = 1'b0; rs_n = 1'b1; ws_n = 1'b1; idx = 5'h0_0; din = 8'h00; stall = 1'b0;
      oe_q = 1'b0;
      dreq = 4'h0;
      void'($urandom(26958));
      repeat (6) @(posedge clock_i);
      rst_n_i <= 1'b1;
      rd(DCP_IDX_ALL_MASK, 8'h0F);
      rd(DCP_IDX_SW_REQ, 8'hF0);
      dreq <= 4'h5;
      rd(DCP_IDX_CMD_STAT, 8'h50);
      `CHK(valid, 1'b0)
      dreq <= 4'h0;
      rd(DCP_IDX_CMD_STAT, 8'h00);
      wr(DCP_IDX_CMD_STAT, 8'h04);
      for (int c = 0; c < 4; c++) begin
         m[c] = {6'($urandom), 2'(c)};
         if (m[c][3:2] == 2'b11) m[c][3] = 1'b0;
         wr(DCP_IDX_MODE, m[c]);
      end
      wr(DCP_IDX_CLR_MCNT, 8'($urandom));
      for (int c = 0; c < 4; c++) rd(DCP_IDX_MODE, {m[c][7:2], 2'b11});
      wr(DCP_IDX_SW_REQ, 8'h05);
      wr(DCP_IDX_SW_REQ, 8'h07);
      rd(DCP_IDX_SW_REQ, 8'hFA);
      wr(DCP_IDX_SW_REQ, 8'h01);
      rd(DCP_IDX_SW_REQ, 8'hF8);
      wr(DCP_IDX_SW_REQ, 8'h03);
      wr(DCP_IDX_SGL_MASK, 8'h01);
      rd(DCP_IDX_ALL_MASK, 8'h0D);
      wr(DCP_IDX_ALL_MASK, 8'hFA);
      rd(DCP_IDX_ALL_MASK, 8'h0A);
      wr(DCP_IDX_CLR_MASK, 8'($urandom));
      rd(DCP_IDX_ALL_MASK, 8'h00);
      // channel 3: count 9, block, down, read, masked
      wr(DCP_IDX_CLR_PTR, 8'($urandom));
      a3 = 16'($urandom);
      wr(5'h0_6, a3[7:0]);
      wr(5'h0_6, a3[15:8]);
      wr(5'h0_7, 8'h09);
      wr(5'h0_7, 8'h00);
      wr(DCP_IDX_MODE, 8'hAB);
      wr(DCP_IDX_SGL_MASK, 8'h07);
      for (int i = 0; i < 10; i++) xq.push_back({2'd3, 2'd2, a3 - 16'(i), i == 9});
      stall <= 1'b1;
      wr(DCP_IDX_SW_REQ, 8'h07);
      repeat (20) @(posedge clock_i);
      `CHK(valid, 1'b0)
      wr(DCP_IDX_CMD_STAT, 8'h00);
      repeat (30) @(posedge clock_i);
      stall <= 1'b0;
      for (int i = 0; i < 300 && xq.size() > 0; i++) @(posedge clock_i);
      `CHK(xq.size(), 0)
      rd(DCP_IDX_CMD_STAT, 8'h08);
      rd(DCP_IDX_CMD_STAT, 8'h00);
      rd(DCP_IDX_ALL_MASK, 8'h08);
      // memory-to-memory: ch0 count 5 held at address 0, ch1 count 1 ends both
      wr(DCP_IDX_CMD_STAT, 8'h04);
      wr(5'h0_1, 8'h05);
      wr(5'h0_1, 8'h00);
      wr(5'h0_3, 8'h01);
      wr(5'h0_3, 8'h00);
      wr(DCP_IDX_MODE, 8'h80);
      wr(DCP_IDX_CMD_STAT, 8'h03);
      xq.push_back({2'd0, 2'd2, 16'h0000, 1'b0});
      xq.push_back({2'd1, 2'd1, 16'h0000, 1'b0});
      xq.push_back({2'd0, 2'd2, 16'h0000, 1'b0});
      xq.push_back({2'd1, 2'd1, m[1][5] ? 16'hFFFF : 16'h0001, 1'b1});
      wr(DCP_IDX_SW_REQ, 8'h04);
      for (int i = 0; i < 300 && xq.size() > 0; i++) @(posedge clock_i);
      `CHK(xq.size(), 0)
      wr(DCP_IDX_MCLR, 8'($urandom));
      rd(DCP_IDX_ALL_MASK, 8'h0F);
      rd(DCP_IDX_CMD_RD, 8'h00);
      rd(DCP_IDX_SW_REQ, 8'hF0);
      repeat (4) @(posedge clock_i);
      `CHK(rq.size(), 0)
      test_done();
   end
endmodule
`default_nettype wire
